// file: src/jtag_tap.sv
// Boundary-scan test access port: state machine, instruction, bypass, id and boundary registers.
// Assumes the test clock comes from an external controller and runs only while it tests;
// memory pin levels arrive on clk_in and cross into the test clock domain by a toggle handshake.
//
// Overview of operation
// - Standard state machine, instruction decoding and serial register paths.
// - Port resets at power-up only once test clock toggles; state undefined until then.
// - Mode-select and data-in inputs have pull-ups to a defined level; the clock has none.
// - Inputs sampled on rising test-clock edge; outputs change on falling edge.
// - Mode-select sampled on rising edge alone steers the state machine.
// - Undriven mode-select behaves as logic one.
// - Undriven data-in shifts in logic one.
// - One serial register between data-in and data-out, chosen by state and instruction.
// - Data-out driven only in some states, from selected register end, after falling edge.
// - Five rising edges with mode-select high reach logic-reset state.
// - Three-bit instruction register preset to identification at power-up and reset state.
// - Instruction capture loads low bits 01; new instruction acts at update.
// - One-bit bypass and 32-bit id register, captured fixed, shifted out lsb first.
`timescale 1ns/1ps

module jtag_tap (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tms_driven_in,
    input wire logic tdi_in,
    input wire logic tdi_driven_in,
    input wire logic [tap_pkg::BSR_W-1:0] pins_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output tap_pkg::ring_drive_t ring_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Memory clock side

    logic reset_q;
    logic [tap_pkg::BSR_W-1:0] pin_q;
    logic [tap_pkg::BSR_W-1:0] pin_hold_q;
    logic pin_req_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic pin_ack_q;

    always_ff @(posedge clk_in) begin
        reset_q <= reset_in;
    end

    // Pin levels captured on the memory clock; only the boundary path uses them
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pin_q <= tap_pkg::BSR_RESET;
        end else begin
            pin_q <= pins_in;
        end
    end

    // Snapshot stands still until the test clock side has taken it, so no word is torn
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pin_hold_q <= tap_pkg::BSR_RESET;
            pin_req_q <= 1'h0;
        end else if (ack_s2_q == pin_req_q) begin
            pin_hold_q <= pin_q;
            pin_req_q <= ~pin_req_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_s1_q <= 1'h0;
            ack_s2_q <= 1'h0;
        end else begin
            ack_s1_q <= pin_ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings into the test clock domain

    logic rst_s1_q;
    logic rst_s2_q;
    logic req_s1_q;
    logic req_s2_q;
    logic [tap_pkg::BSR_W-1:0] pin_tck_q;

    // Power-up reset held as a level; needs test clock edges to take hold
    always_ff @(posedge tck_in) begin
        rst_s1_q <= reset_q;
        rst_s2_q <= rst_s1_q;
    end

    always_ff @(posedge tck_in) begin
        if (rst_s2_q) begin
            req_s1_q <= 1'h0;
            req_s2_q <= 1'h0;
        end else begin
            req_s1_q <= pin_req_q;
            req_s2_q <= req_s1_q;
        end
    end

    // Copy lags the pins by a few test clocks; pins moving at capture give a stale value
    always_ff @(posedge tck_in) begin
        if (rst_s2_q) begin
            pin_tck_q <= tap_pkg::BSR_RESET;
            pin_ack_q <= 1'h0;
        end else if (req_s2_q != pin_ack_q) begin
            pin_tck_q <= pin_hold_q;
            pin_ack_q <= req_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pull-ups on the test inputs

    logic tms_eff;
    logic tdi_eff;

    always_comb begin
        tms_eff = tms_driven_in ? tms_in : tap_pkg::PULL_LEVEL;
        tdi_eff = tdi_driven_in ? tdi_in : tap_pkg::PULL_LEVEL;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State machine

    function automatic tap_pkg::tap_state_t next_state(input tap_pkg::tap_state_t s, input logic tms);
        tap_pkg::tap_state_t n;
        n = s;
        unique case (s)
            tap_pkg::TEST_LOGIC_RESET: n = tms ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::RUN_TEST_IDLE: n = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::SELECT_DR: n = tms ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
            tap_pkg::CAPTURE_DR: n = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::SHIFT_DR: n = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::EXIT1_DR: n = tms ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
            tap_pkg::PAUSE_DR: n = tms ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
            tap_pkg::EXIT2_DR: n = tms ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
            tap_pkg::UPDATE_DR: n = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::SELECT_IR: n = tms ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::CAPTURE_IR;
            tap_pkg::CAPTURE_IR: n = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::SHIFT_IR: n = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::EXIT1_IR: n = tms ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
            tap_pkg::PAUSE_IR: n = tms ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
            tap_pkg::EXIT2_IR: n = tms ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
            tap_pkg::UPDATE_IR: n = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
        endcase
        return n;
    endfunction

    tap_pkg::tap_state_t state_q;
    tap_pkg::tap_state_t state_d;

    always_comb begin
        state_d = next_state(state_q, tms_eff);
    end

    always_ff @(posedge tck_in) begin
        if (rst_s2_q) begin
            state_q <= tap_pkg::TEST_LOGIC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction register

    logic [tap_pkg::IR_W-1:0] ir_sh_q;
    logic [tap_pkg::IR_W-1:0] ir_q;
    logic [tap_pkg::IR_W-1:0] ir_d;

    always_ff @(posedge tck_in) begin
        if (rst_s2_q) begin
            ir_sh_q <= tap_pkg::IR_RESET;
        end else if (state_q == tap_pkg::CAPTURE_IR) begin
            ir_sh_q <= {ir_q[tap_pkg::IR_W-1:2], tap_pkg::IR_CAPTURE_LOW};
        end else if (state_q == tap_pkg::SHIFT_IR) begin
            ir_sh_q <= {tdi_eff, ir_sh_q[tap_pkg::IR_W-1:1]};
        end
    end

    always_comb begin
        if (state_q == tap_pkg::TEST_LOGIC_RESET) begin
            ir_d = tap_pkg::IR_RESET;
        end else if (state_q == tap_pkg::UPDATE_IR) begin
            ir_d = ir_sh_q;
        end else begin
            ir_d = ir_q;
        end
    end

    // Active instruction changes on the falling edge, clear of the rising-edge decode
    always_ff @(negedge tck_in) begin
        if (rst_s2_q) begin
            ir_q <= tap_pkg::IR_RESET;
        end else begin
            ir_q <= ir_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data registers

    function automatic logic uses_ring(input logic [tap_pkg::IR_W-1:0] ins);
        return ins == tap_pkg::INS_EXTEST || ins == tap_pkg::INS_SAMPLE || ins == tap_pkg::INS_SAMPLE_Z;
    endfunction

    function automatic logic uses_id(input logic [tap_pkg::IR_W-1:0] ins);
        return ins == tap_pkg::INS_IDCODE;
    endfunction

    logic bypass_q;
    logic [tap_pkg::ID_W-1:0] id_sh_q;
    logic [tap_pkg::BSR_W-1:0] bsr_sh_q;
    logic [tap_pkg::BSR_W-1:0] bsr_upd_q;
    logic [tap_pkg::BSR_W-1:0] bsr_upd_d;
    logic capture_dr;
    logic shift_dr;

    always_comb begin
        capture_dr = state_q == tap_pkg::CAPTURE_DR;
        shift_dr = state_q == tap_pkg::SHIFT_DR;
    end

    always_ff @(posedge tck_in) begin
        if (rst_s2_q) begin
            bypass_q <= tap_pkg::BYPASS_CAPTURE;
        end else if (capture_dr) begin
            bypass_q <= tap_pkg::BYPASS_CAPTURE;
        end else if (shift_dr) begin
            bypass_q <= tdi_eff;
        end
    end

    always_ff @(posedge tck_in) begin
        if (rst_s2_q) begin
            id_sh_q <= tap_pkg::ID_CODE;
        end else if (capture_dr && uses_id(ir_q)) begin
            id_sh_q <= tap_pkg::ID_CODE;
        end else if (shift_dr && uses_id(ir_q)) begin
            id_sh_q <= {tdi_eff, id_sh_q[tap_pkg::ID_W-1:1]};
        end
    end

    always_ff @(posedge tck_in) begin
        if (rst_s2_q) begin
            bsr_sh_q <= tap_pkg::BSR_RESET;
        end else if (capture_dr && uses_ring(ir_q)) begin
            bsr_sh_q <= pin_tck_q;
        end else if (shift_dr && uses_ring(ir_q)) begin
            bsr_sh_q <= {tdi_eff, bsr_sh_q[tap_pkg::BSR_W-1:1]};
        end
    end

    always_comb begin
        if (state_q == tap_pkg::UPDATE_DR && uses_ring(ir_q)) begin
            bsr_upd_d = bsr_sh_q;
        end else begin
            bsr_upd_d = bsr_upd_q;
        end
    end

    always_ff @(negedge tck_in) begin
        if (rst_s2_q) begin
            bsr_upd_q <= tap_pkg::BSR_RESET;
        end else begin
            bsr_upd_q <= bsr_upd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial output path

    logic dr_bit;

    always_comb begin
        if (uses_id(ir_q)) begin
            dr_bit = id_sh_q[0];
        end else if (uses_ring(ir_q)) begin
            dr_bit = bsr_sh_q[0];
        end else begin
            dr_bit = bypass_q;
        end
    end

    always_ff @(negedge tck_in) begin
        if (rst_s2_q) begin
            tdo_out <= 1'h0;
            tdo_oe_out <= 1'h0;
        end else begin
            tdo_out <= state_q == tap_pkg::SHIFT_IR ? ir_sh_q[0] : dr_bit;
            tdo_oe_out <= state_q == tap_pkg::SHIFT_IR || shift_dr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drive onto the memory pin ring

    // Fed from next values, so the ring moves at the very falling edge of Update-IR, Update-DR or Test-Logic-Reset
    always_ff @(negedge tck_in) begin
        if (rst_s2_q) begin
            ring_out <= '0;
        end else begin
            ring_out.hiz <= ir_d == tap_pkg::INS_SAMPLE_Z;
            ring_out.drive <= ir_d == tap_pkg::INS_EXTEST;
            ring_out.value <= bsr_upd_d;
        end
    end

endmodule // jtag_tap

// file: src/tap_pkg.sv
// Constants, instruction codes, state type and the ring drive struct of the test port.
// Assumes a three-bit instruction register and a small boundary ring of pin cells.
package tap_pkg;

    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 8;

    // Instruction codes; unlisted codes select the bypass cell
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // Fixed pattern forced into the two low instruction bits on capture
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;

    // Identification code; value is arbitrary, bit 0 set as the standard demands
    localparam logic [ID_W-1:0] ID_CODE = 32'h1234_5679;

    // Reset values
    localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;
    localparam logic [BSR_W-1:0] BSR_RESET = 8'h00;
    localparam logic BYPASS_CAPTURE = 1'h0;

    // Level of an input that nobody drives
    localparam logic PULL_LEVEL = 1'h1;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    // What the boundary ring drives onto the memory pins
    typedef struct packed {
        logic hiz;
        logic drive;
        logic [BSR_W-1:0] value;
    } ring_drive_t;

endpackage

// file: test/jtag_tap_checker.sv
// Concurrent checks on the test port pins, bound into every jtag_tap.
// Assumes reset_in is held while the test clock runs.
`timescale 1ns/1ps
module jtag_tap_checker (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tms_driven_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire tap_pkg::ring_drive_t ring_out
);
    logic eff_tms;
    logic tdo_q;
    logic oe_q;
    tap_pkg::ring_drive_t ring_q;
    assign eff_tms = tms_driven_in ? tms_in : 1'b1;
    // Held from each rising edge, so any change before the falling edge is caught
    always_ff @(posedge tck_in) begin
        tdo_q <= tdo_out;
        oe_q <= tdo_oe_out;
        ring_q <= ring_out;
    end
    default clocking cb @(posedge tck_in); endclocking
    default disable iff (reset_in);
    sequence five_ones;
        eff_tms [*5];
    endsequence
    sequence shift_leave;
        tdo_oe_out && eff_tms;
    endsequence
    chk_tdo_falls_only: assert property (@(negedge tck_in) tdo_out == tdo_q)
        else $error("tdo moved off falling edge");
    chk_oe_falls_only: assert property (@(negedge tck_in) tdo_oe_out == oe_q)
        else $error("tdo enable moved off falling edge");
    chk_ring_tck_only: assert property (@(negedge tck_in) ring_out == ring_q)
        else $error("ring moved off falling edge");
    chk_five_ones_reset: assert property (five_ones |=> !tdo_oe_out && !ring_out.hiz && !ring_out.drive)
        else $error("five ones did not reset port");
    chk_reset_quiet: assert property (@(posedge tck_in) disable iff (1'b0) reset_in [*5] |-> !tdo_oe_out && ring_out == '0)
        else $error("port active under reset");
    chk_oe_rise_cause: assert property ($rose(tdo_oe_out) |-> !$past(eff_tms))
        else $error("tdo enabled without shift entry");
    chk_shift_holds: assert property (tdo_oe_out && !eff_tms |=> tdo_oe_out)
        else $error("shift left with select low");
    chk_shift_exit: assert property (shift_leave |=> !tdo_oe_out)
        else $error("tdo still driven after shift exit");
endmodule // jtag_tap_checker
bind jtag_tap jtag_tap_checker jtag_tap_checker_inst (.clk_in, .reset_in, .tck_in, .tms_in, .tms_driven_in,
    .tdo_out, .tdo_oe_out, .ring_out);

// file: test/jtag_host_model.sv
// Boundary-scan controller model driving the test link of one port.
// Assumes callers run one frame at a time; clock stands low between frames.
`timescale 1ns/1ps
module jtag_host_model (
    output logic tck_out,
    output logic tms_out,
    output logic tms_driven_out,
    output logic tdi_out,
    output logic tdi_driven_out,
    input wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tms_driven_out = 1'b1;
        tdi_out = 1'b0;
        tdi_driven_out = 1'b1;
    end
    // Line drive on or off; a released line reads at the port as the pull-up level, not its last value
    task automatic set_drive(input logic tms_on, input logic tdi_on);
        tms_driven_out = tms_on;
        tdi_driven_out = tdi_on;
    endtask
    // Bits lsb first; tdo taken at each rising edge, inputs changed at each falling edge
    task automatic scan(input logic [39:0] tms_v, input logic [39:0] tdi_v, input int n, output logic [39:0] tdo_v);
        #1.3;
        for (int i = 0; i < n; i++) begin
            tms_out = tms_v[i];
            tdi_out = tdi_v[i];
            #15;
            tck_out = 1'b1;
            tdo_v[i] = tdo_in;
            #15;
            tck_out = 1'b0;
        end
        #7.5;
    endtask
endmodule // jtag_host_model

// file: test/jtag_tap_tb.sv
// Self-checking bench of the test port; host model drives the link.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module jtag_tap_tb;
    logic clk_in;
    logic reset_in;
    logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe;
    logic [tap_pkg::BSR_W-1:0] pins;
    tap_pkg::ring_drive_t ring;
    logic [39:0] got;
    logic [31:0] d;
    logic [2:0] prev;
    int fails = 0;
    int cmp_count = 0;
    jtag_tap jtag_tap_inst (.clk_in(clk_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms),
        .tms_driven_in(tms_drv), .tdi_in(tdi), .tdi_driven_in(tdi_drv), .pins_in(pins),
        .tdo_out(tdo), .tdo_oe_out(tdo_oe), .ring_out(ring));
    jtag_host_model jtag_host_model_inst (.tck_out(tck), .tms_out(tms), .tms_driven_out(tms_drv),
        .tdi_out(tdi), .tdi_driven_out(tdi_drv), .tdo_in(tdo));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Idle, capture, shift len bits, update, back to idle; tdi toggles outside shift
    task automatic scan_reg(input logic to_ir, input int len, input logic [31:0] din, output logic [31:0] dout);
        int p;
        logic [39:0] tv;
        logic [39:0] dv;
        logic [39:0] q;
        p = to_ir ? 5 : 4;
        tv = to_ir ? 40'h6 : 40'h2;
        tv[p+len-1] = 1'b1;
        tv[p+len] = 1'b1;
        dv = {20{2'b10}};
        for (int i = 0; i < len; i++) dv[p+i] = din[i];
        jtag_host_model_inst.scan(tv, dv, p + len + 2, q);
        dout = 32'(q >> p);
        check(32'(tdo_oe), 32'h0);
    endtask
    task automatic load_ir(input logic [2:0] code);
        scan_reg(1'b1, 3, 32'(code), d);
        check(32'(d[2:0]), 32'({prev[2], tap_pkg::IR_CAPTURE_LOW}));
        prev = code;
    endtask
    task automatic t_idcode;
        scan_reg(1'b0, 32, 32'h0, d);
        check(d, tap_pkg::ID_CODE);
    endtask
    task automatic t_bypass;
        logic [2:0] codes [4] = '{tap_pkg::INS_BYPASS, 3'h3, 3'h5, 3'h6};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            scan_reg(1'b0, 2, 32'h1, d);
            check(32'(d[1:0]), 32'({1'b1, tap_pkg::BYPASS_CAPTURE}));
        end
    endtask
    task automatic t_float;
        jtag_host_model_inst.set_drive(1'b1, 1'b0);
        scan_reg(1'b0, 3, 32'h0, d);
        check(32'(d[2:1]), 32'h3);
        jtag_host_model_inst.set_drive(1'b0, 1'b1);
        jtag_host_model_inst.scan(40'h0, 40'h0, 5, got);
        jtag_host_model_inst.set_drive(1'b1, 1'b1);
        prev = tap_pkg::IR_RESET;
        t_idcode;
    endtask
    task automatic t_ring;
        load_ir(tap_pkg::INS_SAMPLE);
        scan_reg(1'b0, 8, 32'h3c, d);
        check(32'(d[7:0]), 32'h0a5);
        check(32'(ring), 32'h03c);
        load_ir(tap_pkg::INS_EXTEST);
        check(32'(ring), 32'h13c);
        load_ir(tap_pkg::INS_SAMPLE_Z);
        check(32'(ring), 32'h23c);
    endtask
    initial begin
        reset_in = 1'b1;
        pins = 8'ha5;
        prev = tap_pkg::IR_RESET;
        repeat (5) @(posedge clk_in);
        jtag_host_model_inst.scan(40'hff, 40'h0, 6, got);
        check(32'(tdo_oe), 32'h0);
        check(32'(ring), 32'h0);
        @(negedge clk_in);
        reset_in = 1'b0;
        jtag_host_model_inst.scan(40'hff, 40'h0, 5, got);
        t_idcode;
        t_bypass;
        t_float;
        t_ring;
        wrap_up;
    end
    // Whole run needs under 10 us of test clock; limit leaves a wide margin
    initial begin
        #100000;
        fails++;
        wrap_up;
    end
endmodule // jtag_tap_tb
